/* File: src/tspi_pkg.sv */
package tspi_pkg;

  // system clock and serial clock timing
  localparam int CLK_PERIOD_NS    = 100;
  localparam int SCLK_PERIOD_NS   = 800;
  localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int SCLK_MIN_FREQ_HZ = 1000;
  localparam int SCLK_MAX_FREQ_HZ = 50000000;
  // host samples its synchronised input this many cycles after its own rise
  localparam int HOST_SAMPLE_DELAY = 2;

  // frame layout
  localparam int ADDR_W  = 15;
  localparam int RW_BIT  = 15;
  localparam logic [3:0] CTRL_LAST_BIT = 4'hF;
  localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
  localparam logic [14:0] ADDR_LOW      = 15'h0000;
  localparam logic [14:0] ADDR_LAST_DEF = 15'h7FFF;

  // reset values
  localparam logic CS_N_RESET = 1'b1;
  localparam logic SCLK_RESET = 1'b0;

  typedef enum logic [3:0] {
    DEV_READY = 4'b0001,
    DEV_CTRL  = 4'b0010,
    DEV_DATA  = 4'b0100,
    DEV_DONE  = 4'b1000
  } tspi_dev_state_t;

  typedef enum logic [3:0] {
    HST_IDLE  = 4'b0001,
    HST_SETUP = 4'b0010,
    HST_SHIFT = 4'b0100,
    HST_HOLD  = 4'b1000
  } tspi_host_state_t;

  // shift one received bit into a 16-bit word in either bit order
  function automatic logic [15:0] tspi_shift_in(input logic [15:0] sr, input logic b,
                                                input logic high_bit_first);
    tspi_shift_in = high_bit_first ? {sr[14:0], b} : {b, sr[15:1]};
  endfunction

  // the last eight bits received, whichever end they were shifted into
  function automatic logic [7:0] tspi_byte_of(input logic [15:0] sr,
                                              input logic high_bit_first);
    tspi_byte_of = high_bit_first ? sr[7:0] : sr[15:8];
  endfunction

  // bit to send at position pos of a word whose top bit index is last
  function automatic logic tspi_pick(input logic [15:0] w, input logic [3:0] pos,
                                     input logic [3:0] last, input logic high_bit_first);
    tspi_pick = high_bit_first ? w[4'(last - pos)] : w[pos];
  endfunction

endpackage

/* File: src/tspi_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface tspi_if;
  logic sclk;
  logic chip_select_n;
  logic host_dio;
  logic host_dio_oe;
  logic dev_dio;
  logic dev_dio_oe;
  logic serial_data_out;
  logic serial_data_out_oe;
  logic data_io_pin;
  logic sdo_level;

  // wire levels; an undriven line reads low since no pulls exist
  assign data_io_pin = dev_dio_oe ? dev_dio : (host_dio_oe ? host_dio : 1'b0);
  assign sdo_level   = serial_data_out_oe ? serial_data_out : 1'b0;

  modport device (
    input  sclk, chip_select_n, data_io_pin,
    output dev_dio, dev_dio_oe, serial_data_out, serial_data_out_oe
  );

  modport host (
    output sclk, chip_select_n, host_dio, host_dio_oe,
    input  data_io_pin, sdo_level
  );
endinterface
`default_nettype wire

/* File: src/tspi_device_end.sv */
`timescale 1ns/100ps
`default_nettype none
module tspi_device_end #(
  parameter logic [14:0] LAST_ADDR = tspi_pkg::ADDR_LAST_DEF
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  // serial link
  tspi_if.device           link,
  // port configuration, held stable while selected
  input  wire logic        high_bit_first_i,
  input  wire logic        multi_byte_enable_i,
  input  wire logic        address_step_up_i,
  input  wire logic        separate_output_line_mode_i,
  // register file access
  output logic [14:0]      reg_addr_o,
  output logic [7:0]       reg_wdata_o,
  output logic             reg_write_o,
  output logic             reg_read_o,
  input  wire logic [7:0]  reg_rdata_i,
  // status
  output logic             active_o
);

  tspi_pkg::tspi_dev_state_t state;
  logic [2:0]  sclk_s;
  logic [1:0]  cs_s;
  logic [1:0]  dio_s;
  logic        cs_n;
  logic        rise;
  logic        fall;
  logic        dio_in;
  logic [3:0]  bit_cnt;
  logic [15:0] in_sr;
  logic [15:0] next_in;
  logic        ctrl_done;
  logic        byte_done;
  logic        is_read;
  logic [14:0] addr;
  logic [7:0]  out_sr;
  logic        out_bit;
  logic        dio_oe;
  logic        sdo_oe;

  // next address in a stream, wrapping at both ends of the map
  function automatic logic [14:0] step_addr(input logic [14:0] a, input logic up);
    if (up) begin
      step_addr = (a >= LAST_ADDR) ? tspi_pkg::ADDR_LOW : 15'(a + 15'h0001);
    end else begin
      step_addr = (a == tspi_pkg::ADDR_LOW) ? LAST_ADDR : 15'(a - 15'h0001);
    end
  endfunction

  // pin synchronisers; stage 0 only feeds stage 1
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_s <= {3{tspi_pkg::SCLK_RESET}};
      cs_s   <= {2{tspi_pkg::CS_N_RESET}};
      dio_s  <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], link.sclk};
      cs_s   <= {cs_s[0], link.chip_select_n};
      dio_s  <= {dio_s[0], link.data_io_pin};
    end
  end

  // edges found on synchronised copies, so data and clock share delay
  assign cs_n    = cs_s[1];
  assign rise    = sclk_s[1] & ~sclk_s[2] & ~cs_n;
  assign fall    = ~sclk_s[1] & sclk_s[2] & ~cs_n;
  assign dio_in  = dio_s[1];
  assign next_in = tspi_pkg::tspi_shift_in(in_sr, dio_in, high_bit_first_i);

  assign ctrl_done = rise & (state == tspi_pkg::DEV_CTRL) &
                     (bit_cnt == tspi_pkg::CTRL_LAST_BIT);
  assign byte_done = rise & (state == tspi_pkg::DEV_DATA) &
                     (bit_cnt == tspi_pkg::BYTE_LAST_BIT);

  // framing state; deselect wins over everything
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= tspi_pkg::DEV_READY;
    end else if (cs_n) begin
      state <= tspi_pkg::DEV_READY;
    end else begin
      case (state)
        tspi_pkg::DEV_READY: begin
          state <= tspi_pkg::DEV_CTRL;
        end
        tspi_pkg::DEV_CTRL: begin
          if (ctrl_done) begin
            state <= tspi_pkg::DEV_DATA;
          end
        end
        tspi_pkg::DEV_DATA: begin
          if (byte_done && !multi_byte_enable_i) begin
            state <= tspi_pkg::DEV_DONE;
          end
        end
        tspi_pkg::DEV_DONE: begin
          state <= tspi_pkg::DEV_DONE; // further clocks ignored until deselect
        end
        default: begin
          state <= tspi_pkg::DEV_READY;
        end
      endcase
    end
  end

  // bit position within the control word or current byte
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_cnt <= 4'h0;
    end else if (state == tspi_pkg::DEV_READY) begin
      bit_cnt <= 4'h0;
    end else if (ctrl_done || byte_done) begin
      bit_cnt <= 4'h0;
    end else if (rise && (state == tspi_pkg::DEV_CTRL || state == tspi_pkg::DEV_DATA)) begin
      bit_cnt <= 4'(bit_cnt + 4'h1);
    end
  end

  // receive shift register, captured on rising edges
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_sr <= 16'h0000;
    end else if (state == tspi_pkg::DEV_READY) begin
      in_sr <= 16'h0000;
    end else if (rise) begin
      in_sr <= next_in;
    end
  end

  // direction and address pointer from the control word
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      is_read <= 1'b0;
      addr    <= tspi_pkg::ADDR_LOW;
    end else if (ctrl_done) begin
      is_read <= next_in[tspi_pkg::RW_BIT];
      addr    <= next_in[14:0];
    end else if (byte_done) begin
      addr    <= step_addr(addr, address_step_up_i);
    end
  end

  // register port; a write only ever follows a whole byte, so an abort
  // drops the partial byte while earlier bytes are already stored
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_addr_o  <= tspi_pkg::ADDR_LOW;
      reg_wdata_o <= 8'h00;
      reg_write_o <= 1'b0;
      reg_read_o  <= 1'b0;
    end else begin
      reg_write_o <= 1'b0;
      reg_read_o  <= 1'b0;
      if (ctrl_done) begin
        reg_addr_o <= next_in[14:0];
        reg_read_o <= next_in[tspi_pkg::RW_BIT];
      end else if (byte_done && is_read) begin
        // prefetch the byte for the next stream slot
        reg_addr_o <= step_addr(addr, address_step_up_i);
        reg_read_o <= multi_byte_enable_i;
      end else if (byte_done) begin
        reg_addr_o  <= addr;
        reg_wdata_o <= tspi_pkg::tspi_byte_of(next_in, high_bit_first_i);
        reg_write_o <= (addr <= LAST_ADDR);
      end
    end
  end

  // transmit shift register, loaded the cycle after a read strobe
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_sr  <= 8'h00;
      out_bit <= 1'b0;
    end else if (reg_read_o) begin
      out_sr  <= (reg_addr_o <= LAST_ADDR) ? reg_rdata_i : 8'h00;
    end else if (fall && state == tspi_pkg::DEV_DATA && is_read) begin
      out_bit <= high_bit_first_i ? out_sr[7] : out_sr[0];
      out_sr  <= high_bit_first_i ? {out_sr[6:0], 1'b0} : {1'b0, out_sr[7:1]};
    end
  end

  // output enables; only one data line ever drives the answer
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dio_oe <= 1'b0;
      sdo_oe <= 1'b0;
    end else if (cs_n || state != tspi_pkg::DEV_DATA || !is_read) begin
      dio_oe <= 1'b0;
      sdo_oe <= 1'b0;
    end else if (fall) begin
      dio_oe <= ~separate_output_line_mode_i;
      sdo_oe <= separate_output_line_mode_i;
    end
  end

  // pin drive
  assign link.dev_dio            = out_bit;
  assign link.dev_dio_oe         = dio_oe;
  assign link.serial_data_out    = out_bit;
  assign link.serial_data_out_oe = sdo_oe;
  assign active_o                = (state != tspi_pkg::DEV_READY);

endmodule // tspi_device_end
`default_nettype wire

/* File: src/tspi_host_end.sv */
`timescale 1ns/100ps
`default_nettype none
module tspi_host_end #(
  parameter int HALF_CYCLES = tspi_pkg::SCLK_HALF_CYCLES
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  // serial link
  tspi_if.host             link,
  // transaction request
  input  wire logic        start_i,
  input  wire logic        read_i,
  input  wire logic [14:0] addr_i,
  input  wire logic [7:0]  byte_count_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        high_bit_first_i,
  input  wire logic        separate_output_line_mode_i,
  // answer
  output logic             busy_o,
  output logic             wdata_take_o,
  output logic [7:0]       rdata_o,
  output logic             rdata_valid_o
);

  localparam logic [7:0] PH_FALL = 8'(HALF_CYCLES - 1);
  localparam logic [7:0] PH_RISE = 8'(2 * HALF_CYCLES - 1);
  localparam logic [7:0] PH_SAMP = 8'(tspi_pkg::HOST_SAMPLE_DELAY);

  tspi_pkg::tspi_host_state_t state;
  logic [7:0]  ph;
  logic [3:0]  pos;
  logic        in_ctrl;
  logic [15:0] word;
  logic [7:0]  bytes_left;
  logic        rd;
  logic        hbf;
  logic        sep;
  logic [15:0] rx_sr;
  logic [1:0]  dio_s;
  logic [1:0]  sdo_s;
  logic        sclk;
  logic        cs_n;
  logic        dout;
  logic        dio_oe;
  logic        word_end;

  // synchronise device outputs
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dio_s <= 2'h0;
      sdo_s <= 2'h0;
    end else begin
      dio_s <= {dio_s[0], link.data_io_pin};
      sdo_s <= {sdo_s[0], link.sdo_level};
    end
  end

  assign word_end = in_ctrl ? (pos == tspi_pkg::CTRL_LAST_BIT)
                            : (pos == tspi_pkg::BYTE_LAST_BIT);

  // sequencer: clock divider, bit launch on falls, framing with select
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= tspi_pkg::HST_IDLE;
      ph           <= 8'h00;
      pos          <= 4'h0;
      in_ctrl      <= 1'b1;
      word         <= 16'h0000;
      bytes_left   <= 8'h00;
      rd           <= 1'b0;
      hbf          <= 1'b1;
      sep          <= 1'b1;
      sclk         <= tspi_pkg::SCLK_RESET;
      cs_n         <= tspi_pkg::CS_N_RESET;
      dout         <= 1'b0;
      dio_oe       <= 1'b0;
      wdata_take_o <= 1'b0;
    end else begin
      wdata_take_o <= 1'b0;
      case (state)
        tspi_pkg::HST_IDLE: begin
          if (start_i) begin
            word    <= {read_i, addr_i};
            rd      <= read_i;
            hbf     <= high_bit_first_i;
            sep     <= separate_output_line_mode_i;
            bytes_left <= (byte_count_i == 8'h00) ? 8'h01 : byte_count_i;
            pos     <= 4'h0;
            in_ctrl <= 1'b1;
            ph      <= 8'h00;
            cs_n    <= 1'b0;
            dout    <= tspi_pkg::tspi_pick({read_i, addr_i}, 4'h0,
                         tspi_pkg::CTRL_LAST_BIT, high_bit_first_i);
            dio_oe  <= 1'b1;
            state   <= tspi_pkg::HST_SETUP;
          end
        end
        tspi_pkg::HST_SETUP: begin
          ph <= 8'(ph + 8'h01);
          if (ph == PH_FALL) begin
            ph    <= 8'h00;
            sclk  <= 1'b1;
            state <= tspi_pkg::HST_SHIFT;
          end
        end
        tspi_pkg::HST_SHIFT: begin
          ph <= (ph == PH_RISE) ? 8'h00 : 8'(ph + 8'h01);
          if (ph == PH_RISE) begin
            sclk <= 1'b1;
          end
          if (ph == PH_FALL) begin
            sclk <= 1'b0;
            pos  <= word_end ? 4'h0 : 4'(pos + 4'h1);
            if (!word_end) begin
              dout <= tspi_pkg::tspi_pick(word, 4'(pos + 4'h1),
                        in_ctrl ? tspi_pkg::CTRL_LAST_BIT : tspi_pkg::BYTE_LAST_BIT, hbf);
            end else if (!in_ctrl && bytes_left == 8'h01) begin
              dio_oe <= 1'b0;
              ph     <= 8'h00;
              state  <= tspi_pkg::HST_HOLD;
            end else begin
              in_ctrl <= 1'b0;
              if (!in_ctrl) begin
                bytes_left <= 8'(bytes_left - 8'h01);
              end
              if (rd) begin
                dio_oe <= 1'b0;
              end else begin
                word         <= {8'h00, wdata_i};
                wdata_take_o <= 1'b1;
                dout <= tspi_pkg::tspi_pick({8'h00, wdata_i}, 4'h0,
                          tspi_pkg::BYTE_LAST_BIT, hbf);
              end
            end
          end
        end
        tspi_pkg::HST_HOLD: begin
          ph <= 8'(ph + 8'h01);
          if (ph == PH_FALL) begin
            cs_n <= 1'b1;
          end
          if (ph == PH_RISE) begin
            state <= tspi_pkg::HST_IDLE; // select stays high long enough to be seen
          end
        end
        default: begin
          state <= tspi_pkg::HST_IDLE;
        end
      endcase
    end
  end

  // read capture a little after each rise to allow for synchronisers
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_sr         <= 16'h0000;
      rdata_o       <= 8'h00;
      rdata_valid_o <= 1'b0;
    end else begin
      rdata_valid_o <= 1'b0;
      if (state == tspi_pkg::HST_SHIFT && ph == PH_SAMP && rd && !in_ctrl) begin
        rx_sr <= tspi_pkg::tspi_shift_in(rx_sr, sep ? sdo_s[1] : dio_s[1], hbf);
      end
      if (state == tspi_pkg::HST_SHIFT && ph == PH_FALL && rd && !in_ctrl && word_end) begin
        rdata_o       <= tspi_pkg::tspi_byte_of(rx_sr, hbf);
        rdata_valid_o <= 1'b1;
      end
    end
  end

  // pin drive
  assign link.sclk          = sclk;
  assign link.chip_select_n = cs_n;
  assign link.host_dio      = dout;
  assign link.host_dio_oe   = dio_oe;
  assign busy_o             = (state != tspi_pkg::HST_IDLE);

endmodule // tspi_host_end
`default_nettype wire

/* File: verification/tspi_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module tspi_checker (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // link signals
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic host_dio,
  input wire logic host_dio_oe,
  input wire logic dev_dio,
  input wire logic dev_dio_oe,
  input wire logic serial_data_out_oe,
  // wire mode shared by both ends
  input wire logic separate_output_line_mode_i
);
  // one domain, so clock and disable are given once
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  // host side framing and clock shape
  a_clock_when_selected: assert property (sclk |-> !chip_select_n)
    else $error("serial clock high while deselected");
  a_clock_high_width: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("serial clock high phase not four cycles");
  a_select_leads_clock: assert property ($rose(sclk) |-> !$past(chip_select_n, 4))
    else $error("clock rose too soon after select");
  a_frame_gap: assert property ($rose(chip_select_n) |-> chip_select_n [*4])
    else $error("select high gap too short");
  // launch only while the clock is low
  a_host_launch_fall: assert property (
    sclk |-> $stable(host_dio) && $stable(host_dio_oe))
    else $error("host data moved while clock high");
  a_dev_launch_fall: assert property (
    sclk |-> $stable(dev_dio) && $stable(dev_dio_oe))
    else $error("device data moved while clock high");
  // pin use per wire mode
  a_dev_output_line: assert property (separate_output_line_mode_i |-> !dev_dio_oe)
    else $error("shared pin driven in four-wire mode");
  a_dev_shared_line: assert property (
    !separate_output_line_mode_i |-> !serial_data_out_oe)
    else $error("output line driven in three-wire mode");
  // oe may lag select by the sync depth, hence six cycles
  a_float_deselected: assert property (
    chip_select_n [*6] |-> !dev_dio_oe && !serial_data_out_oe)
    else $error("device drives while deselected");
  a_no_contention: assert property (!(host_dio_oe && dev_dio_oe))
    else $error("both ends drive the shared pin");

  // main scenarios
  c_shared_read: cover property ($rose(dev_dio_oe));
  c_line_read: cover property ($rose(serial_data_out_oe));
  c_frame_end: cover property ($rose(chip_select_n));
endmodule // tspi_checker
`default_nettype wire

/* File: verification/transceiver_spi_slave_port_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module transceiver_spi_slave_port_tb_top;
  localparam logic [14:0] LAST = 15'h0020;
  logic        clock_i = 1'b0;
  logic        rst_n = 1'b0;
  logic        host_rstn = 1'b1;
  logic        start_i = 1'b0;
  logic        read_i = 1'b0;
  logic [14:0] addr_i = 15'h0000;
  logic [7:0]  byte_count_i = 8'h01;
  logic [7:0]  wdata_i = 8'h00;
  logic        hbf = 1'b1;
  logic        wire4 = 1'b1;
  logic        stream = 1'b0;
  logic        up = 1'b1;
  logic        busy_o, wdata_take_o, rdata_valid_o, reg_write_o, active_o;
  logic [7:0]  rdata_o, reg_wdata_o;
  logic [14:0] reg_addr_o;
  logic [7:0]  regs [0:63];
  logic [7:0]  wq [0:7];
  logic [7:0]  rq [0:7];
  logic        wb [0:63];
  int          nb, fails, n_tests, cyc;

  tspi_if link ();

  // host reset doubles as the way to raise select mid-frame
  tspi_host_end u_tspi_host_end (
    .clock_i(clock_i), .resetn_i(rst_n & host_rstn), .link(link.host),
    .start_i(start_i), .read_i(read_i), .addr_i(addr_i), .byte_count_i(byte_count_i),
    .wdata_i(wdata_i), .high_bit_first_i(hbf), .separate_output_line_mode_i(wire4),
    .busy_o(busy_o), .wdata_take_o(wdata_take_o), .rdata_o(rdata_o),
    .rdata_valid_o(rdata_valid_o));

  // undefined places answer junk so forced zeros show
  tspi_device_end #(.LAST_ADDR(LAST)) u_tspi_device_end (
    .clock_i(clock_i), .resetn_i(rst_n), .link(link.device), .high_bit_first_i(hbf),
    .multi_byte_enable_i(stream), .address_step_up_i(up), .separate_output_line_mode_i(wire4),
    .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o), .reg_write_o(reg_write_o),
    .reg_read_o(), .reg_rdata_i((reg_addr_o > LAST) ? 8'hA5 : regs[reg_addr_o[5:0]]),
    .active_o(active_o));

  tspi_checker u_tspi_checker (
    .clock_i(clock_i), .resetn_i(rst_n & host_rstn), .sclk(link.sclk),
    .chip_select_n(link.chip_select_n), .host_dio(link.host_dio),
    .host_dio_oe(link.host_dio_oe), .dev_dio(link.dev_dio), .dev_dio_oe(link.dev_dio_oe),
    .serial_data_out_oe(link.serial_data_out_oe), .separate_output_line_mode_i(wire4));

  // clock, hang guard, register file, wire capture
  always #50 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 12000) begin
      fails++;
      $display("BAD %0t run timed out", $time);
      give_verdict();
    end
  end
  always @(posedge clock_i) if (reg_write_o === 1'b1) regs[reg_addr_o[5:0]] <= reg_wdata_o;
  always @(posedge link.sclk) if (link.chip_select_n === 1'b0) begin
    wb[nb[5:0]] = link.data_io_pin;
    nb++;
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  // bit expected at wire position p of a one-byte frame
  function automatic logic exp_bit(input logic rd, input logic [14:0] a, input logic [7:0] d,
                                   input int p);
    logic [15:0] cw;
    cw = {rd, a};
    if (p < 16) return hbf ? cw[15 - p] : (p < 15 ? a[p] : rd);
    return hbf ? d[23 - p] : d[p - 16];
  endfunction

  task automatic wcheck(input logic rd, input logic [14:0] a, input logic [7:0] d, input int n);
    logic [23:0] got;
    logic [23:0] exp;
    for (int p = 0; p < 24; p++) begin
      got[p] = (p < n) ? wb[p] : 1'b0;
      exp[p] = (p < n) ? exp_bit(rd, a, d, p) : 1'b0;
    end
    chk(got, exp, "wire order");
    chk(24'(nb), 24'h18, "bit count");
  endtask

  // one frame; ab >= 0 pulls the host down at that cycle
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] n, input int ab);
    int k;
    int i;
    int t;
    k = 0;
    i = 0;
    t = 0;
    nb = 0;
    read_i = rd;
    addr_i = a;
    byte_count_i = n;
    wdata_i = wq[0];
    start_i = 1'b1;
    @(negedge clock_i);
    start_i = 1'b0;
    @(negedge clock_i);
    while (busy_o !== 1'b0 && t < 2000) begin
      if (wdata_take_o === 1'b1) begin
        k++;
        wdata_i = wq[k[2:0]];
      end
      if (rdata_valid_o === 1'b1) begin
        rq[i[2:0]] = rdata_o;
        i++;
      end
      if (t == ab) begin
        host_rstn = 1'b0;
        repeat (2) @(negedge clock_i);
        host_rstn = 1'b1;
      end
      t++;
      @(negedge clock_i);
    end
    if (t >= 2000) begin
      fails++;
      $display("BAD %0t transfer hung", $time);
    end
    repeat (8) @(negedge clock_i);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 64; i++) regs[i] = 8'h00;
    regs[1] = 8'h24;
    regs[32] = 8'h5B;
    repeat (3) @(negedge clock_i);
    rst_n = 1'b1;
    repeat (5) @(negedge clock_i);
    // each bit order in each wire mode
    for (int m = 0; m < 4; m++) begin
      {wire4, hbf} = 2'(m);
      // mode word to the configuration place first, as a host would
      wq[0] = wire4 ? 8'h3C : 8'h24;
      xfer(1'b0, 15'h0000, 8'h01, -1);
      chk(24'(regs[0]), 24'(wq[0]), "mode word");
      wq[0] = 8'h96 ^ 8'(m);
      xfer(1'b0, 15'h0009, 8'h01, -1);
      wcheck(1'b0, 15'h0009, wq[0], 24);
      xfer(1'b1, 15'h0009, 8'h01, -1);
      chk(24'(rq[0]), 24'(wq[0]), "readback");
      wcheck(1'b1, 15'h0009, wq[0], wire4 ? 16 : 24);
    end
    $display("test modes done");
    // undefined place: write lost, read zero
    wq[0] = 8'h77;
    xfer(1'b0, 15'h0030, 8'h01, -1);
    chk(24'(regs[48]), 24'h0, "undef write");
    xfer(1'b1, 15'h0030, 8'h01, -1);
    chk(24'(rq[0]), 24'h0, "undef read");
    // single mode drops a second byte
    wq[0] = 8'h11;
    wq[1] = 8'h22;
    xfer(1'b0, 15'h0010, 8'h02, -1);
    chk(24'({regs[15], regs[16], regs[17]}), 24'h1100, "single");
    $display("test undefined and single done");
    // streamed read stepping down past zero
    stream = 1'b1;
    up = 1'b0;
    xfer(1'b1, 15'h0001, 8'h03, -1);
    chk({rq[0], rq[1], rq[2]}, 24'h243C5B, "down wrap");
    // streamed write stepping up past the last place; zero written once
    up = 1'b1;
    wq[0] = 8'hA1;
    wq[1] = 8'hB2;
    wq[2] = 8'hC3;
    xfer(1'b0, 15'h001F, 8'h03, -1);
    chk({regs[31], regs[32], regs[0]}, 24'hA1B2C3, "up wrap");
    $display("test streaming done");
    // aborts inside the control word and inside the first byte
    stream = 1'b0;
    wq[0] = 8'hEE;
    xfer(1'b0, 15'h0005, 8'h01, 60);
    chk(24'(regs[5]), 24'h0, "abort control");
    chk(24'(active_o), 24'h0, "ready state");
    xfer(1'b0, 15'h0005, 8'h01, 160);
    chk(24'(regs[5]), 24'h0, "abort first byte");
    // abort in the third streamed byte keeps the first two
    stream = 1'b1;
    wq[0] = 8'h5A;
    wq[1] = 8'h6B;
    wq[2] = 8'h7C;
    xfer(1'b0, 15'h0008, 8'h03, 290);
    chk({regs[8], regs[9], regs[10]}, 24'h5A6B00, "abort stream");
    stream = 1'b0;
    xfer(1'b1, 15'h0008, 8'h01, -1);
    chk(24'(rq[0]), 24'h5A, "ready after abort");
    $display("test aborts done");
    give_verdict();
  end
endmodule // transceiver_spi_slave_port_tb_top
`default_nettype wire
